// ---- tumsb_checker.sv ----
// Concurrent checks on the sideband, self-test and event link.
// Assumes one clock domain; placed beside the link interface.
`timescale 1ns/1ns
`default_nettype none

module tumsb_checker
  import tumsb_pkg::*;
#(
  parameter int ROW_AW = ROW_AW_DEF
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Link signals
  input wire logic arvalid,
  input wire logic rd_nonsecure_side,
  input wire logic sec_debug_en,
  input wire logic scan_test,
  input wire logic bist_req,
  input wire logic bist_ack,
  input wire logic bist_rden,
  input wire logic bist_wren,
  input wire logic [ROW_AW-1:0] bist_addr,
  input wire logic [BIST_DW-1:0] bist_wdata,
  input wire logic [BIST_DW-1:0] bist_rdata,
  input wire logic ev_cycle,
  input wire logic cycle_div_tick_event,
  input wire logic ev_rd_access,
  input wire logic secure_config_fault_int,
  input wire logic secure_global_fault_int,
  input wire logic secure_merged_int
);
  // ****************************************
  // Helper state
  // ****************************************
  // The divider gap is judged only after a tick seen clear of test mode, since test mode
  // freezes the divider and would otherwise stretch the gap.
  logic [6:0] gap;
  logic clean;
  logic wrote;
  logic [ROW_AW-1:0] last_addr;
  logic [BIST_DW-1:0] last_data;

  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_rst);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gap <= 7'h00;
      clean <= 1'b0;
      wrote <= 1'b0;
    end else begin
      gap <= cycle_div_tick_event ? 7'h00 : gap + 7'h01;
      clean <= scan_test ? 1'b0 : (cycle_div_tick_event ? 1'b1 : clean);
      if (bist_ack && bist_wren) begin
        wrote <= 1'b1;
        last_addr <= bist_addr;
        last_data <= bist_wdata;
      end
    end
  end

  AST_ACK_ANSWER: assert property ($rose(bist_req) |=> bist_ack)
    else $error("acknowledge late");
  AST_ACK_CAUSE: assert property (bist_ack |-> $past(bist_req))
    else $error("acknowledge without request");
  AST_RDATA_LAT: assert property (bist_ack && bist_rden && !bist_wren && wrote
    && bist_addr == last_addr |-> ##3 bist_rdata == $past(last_data, 3))
    else $error("self-test read data wrong");
  AST_CYCLE_EVT: assert property (!scan_test [*4] |-> ev_cycle)
    else $error("cycle event missing");
  AST_TEST_QUIET: assert property (scan_test [*3] |->
    !ev_cycle && !cycle_div_tick_event && !ev_rd_access)
    else $error("event in test mode");
  AST_DIV_GAP: assert property (clean |-> cycle_div_tick_event == (gap == 7'h3F))
    else $error("divided tick spacing wrong");
  AST_RD_EVT: assert property (arvalid && (rd_nonsecure_side || sec_debug_en)
    && !$past(scan_test) |=> ev_rd_access)
    else $error("read access event missing");
  AST_RD_CAUSE: assert property (ev_rd_access |-> $past(arvalid)
    && ($past(rd_nonsecure_side) || $past(sec_debug_en)))
    else $error("read access event without cause");
  AST_MERGED_S: assert property (secure_merged_int ==
    (secure_config_fault_int || secure_global_fault_int))
    else $error("secure merged interrupt wrong");
endmodule

`default_nettype wire

// ---- tumsb_dev.sv ----
// Translation unit end: sideband capture, fault interrupts, cache self-test port, events.
// Assumes the far end drives every link input except the walk tie-off, which is a parameter, from flops on the same clock.
// Function
// R01: Read security bit taken with read valid.
// R02: Write security bit taken with write valid.
// R03: Index sidebands 0-8 bits, only without security bits.
// R04: Source identity sidebands taken with their valids.
// R05: Secure and non-secure configuration fault interrupts.
// R06: Secure and non-secure global fault interrupts.
// R07: Performance and non-secure context interrupts.
// R08: Secure and non-secure combined interrupts.
// R09: Self-test port exists only with RAM storage.
// R10: Self-test acknowledge before any operation.
// R11: Row address width is log2 of depth.
// R12: Self-test read data valid three clocks later.
// R13: Secure events counted only with debug enable.
// R14: Coherent walk tie-off fixed after reset.
// R15: Scan tie-off selects functional or test mode.
// R16: Event pulse on every clock; the code gives none while test mode is set.
// R17: Event pulse every 64th clock; the code gives none in test mode, where the divider holds.
// R18: Event pulses per write and read access; the code gives none in test mode.
// R19: Event pulses per write and read refill; the code gives none in test mode.
// R20: Each event is a one-cycle pulse.
// R21: Interrupts are levels held until cleared.
`timescale 1ns/1ns
`default_nettype none

module tumsb_dev
  import tumsb_pkg::*;
#(
  parameter bit HAS_NS = 1'b1,
  parameter bit HAS_RAM = 1'b1,
  parameter int ROW_AW = ROW_AW_DEF,
  parameter logic [2**SSD_W-1:0] SSD_NS_TABLE = '1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Link
  tumsb_if.dev_mp link,
  // Fault sources and clears
  input wire logic [N_INT-1:0] i_fault_set,
  input wire logic [N_INT-1:0] i_fault_clr,
  // Cache refill strobes
  input wire logic i_rd_refill,
  input wire logic i_wr_refill,
  // Captured transaction attributes
  output logic o_rd_valid,
  output logic o_rd_ns,
  output logic [SID_W-1:0] o_rd_sid,
  output logic o_wr_valid,
  output logic o_wr_ns,
  output logic [SID_W-1:0] o_wr_sid,
  // Tie-off state
  output logic o_coherent_walk,
  output logic o_test_mode
);
  // ****************************************
  // Helpers
  // ****************************************
  // With the security bits present the index lines are ignored entirely.
  function automatic logic sec_ns(input logic ns_bit, input logic [SSD_W-1:0] idx);
    sec_ns = HAS_NS ? ns_bit : SSD_NS_TABLE[idx]; // [R03]
  endfunction

  function automatic logic may_count(input logic ns, input logic dbg);
    may_count = ns | dbg; // [R13]
  endfunction

  // ****************************************
  // Sideband capture and events
  // ****************************************
  logic rd_v, next_rd_v, rd_ns, next_rd_ns, wr_v, next_wr_v, wr_ns, next_wr_ns;
  logic [SID_W-1:0] rd_sid, next_rd_sid, wr_sid, next_wr_sid;
  logic [N_EVT-1:0] evt, next_evt;
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic cttw, next_cttw, cttw_done, next_cttw_done, test_q, next_test_q;
  logic ar_ns, aw_ns;

  always_comb begin
    ar_ns = sec_ns(link.rd_nonsecure_side, link.rd_ssd_index);
    aw_ns = sec_ns(link.wr_nonsecure_side, link.wr_ssd_index);
    next_rd_v = link.arvalid;
    next_rd_ns = rd_ns;
    next_rd_sid = rd_sid;
    if (link.arvalid) begin
      next_rd_ns = ar_ns; // [R01]
      next_rd_sid = link.rd_source_identity; // [R04]
    end
    next_wr_v = link.awvalid;
    next_wr_ns = wr_ns;
    next_wr_sid = wr_sid;
    if (link.awvalid) begin
      next_wr_ns = aw_ns; // [R02]
      next_wr_sid = link.wr_source_identity; // [R04]
    end
    // Test mode freezes the divider so scan patterns see a stable state.
    next_div_cnt = test_q ? div_cnt : div_cnt + 1'b1; // [R15]
    next_evt = '0;
    if (!test_q) begin
      next_evt[EV_CLK] = 1'b1; // [R16]
      next_evt[EV_DIV] = (div_cnt == DIV_W'(DIV_TICK - 1)); // [R17]
      next_evt[EV_RD_ACC] = link.arvalid && may_count(ar_ns, link.sec_debug_en); // [R18]
      next_evt[EV_WR_ACC] = link.awvalid && may_count(aw_ns, link.sec_debug_en); // [R18]
      next_evt[EV_RD_REF] = i_rd_refill && may_count(rd_ns, link.sec_debug_en); // [R19]
      next_evt[EV_WR_REF] = i_wr_refill && may_count(wr_ns, link.sec_debug_en); // [R19]
    end
    // The walk tie-off is caught once after reset; later changes are not followed.
    next_cttw = cttw_done ? cttw : link.coherent_walk; // [R14]
    next_cttw_done = 1'b1;
    next_test_q = link.scan_test; // [R15]
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rd_v <= 1'b0;
      rd_ns <= 1'b0;
      rd_sid <= '0;
      wr_v <= 1'b0;
      wr_ns <= 1'b0;
      wr_sid <= '0;
      evt <= '0;
      div_cnt <= '0;
      cttw <= 1'b0;
      cttw_done <= 1'b0;
      test_q <= 1'b0;
    end else begin
      rd_v <= next_rd_v;
      rd_ns <= next_rd_ns;
      rd_sid <= next_rd_sid;
      wr_v <= next_wr_v;
      wr_ns <= next_wr_ns;
      wr_sid <= next_wr_sid;
      evt <= next_evt;
      div_cnt <= next_div_cnt;
      cttw <= next_cttw;
      cttw_done <= next_cttw_done;
      test_q <= next_test_q;
    end
  end

  assign o_rd_valid = rd_v;
  assign o_rd_ns = rd_ns;
  assign o_rd_sid = rd_sid;
  assign o_wr_valid = wr_v;
  assign o_wr_ns = wr_ns;
  assign o_wr_sid = wr_sid;
  assign o_coherent_walk = cttw;
  assign o_test_mode = test_q;
  // Every event is a registered single-cycle strobe.
  assign link.ev_cycle = evt[EV_CLK]; // [R20]
  assign link.cycle_div_tick_event = evt[EV_DIV];
  assign link.ev_wr_access = evt[EV_WR_ACC];
  assign link.ev_rd_access = evt[EV_RD_ACC];
  assign link.ev_wr_refill = evt[EV_WR_REF];
  assign link.ev_rd_refill = evt[EV_RD_REF];

  // ****************************************
  // Fault interrupts
  // ****************************************
  logic [N_INT-1:0] flt, next_flt;

  always_comb begin
    // A new fault in the clearing cycle survives the clear.
    next_flt = (flt & ~i_fault_clr) | i_fault_set; // [R21]
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flt <= '0;
    end else begin
      flt <= next_flt;
    end
  end

  assign link.secure_config_fault_int = flt[INT_CFG_S]; // [R05]
  assign link.nonsecure_config_fault_int = flt[INT_CFG_NS]; // [R05]
  assign link.secure_global_fault_int = flt[INT_GLB_S]; // [R06]
  assign link.nonsecure_global_fault_int = flt[INT_GLB_NS]; // [R06]
  assign link.perf_int = flt[INT_PERF]; // [R07]
  assign link.nonsecure_context_fault_int = flt[INT_CXT_NS]; // [R07]
  assign link.secure_merged_int = flt[INT_CFG_S] | flt[INT_GLB_S]; // [R08]
  assign link.nonsecure_merged_int = flt[INT_CFG_NS] | flt[INT_GLB_NS] // [R08]
    | flt[INT_CXT_NS] | flt[INT_PERF];

  // ****************************************
  // Cache self-test port
  // ****************************************
  generate
    if (HAS_RAM) begin : g_bist
      localparam int DEPTH = 2**ROW_AW; // [R11]
      logic [BIST_DW-1:0] mem [DEPTH];
      logic ack, next_ack;
      logic [ROW_AW-1:0] raddr, next_raddr;
      logic [BIST_DW-1:0] rd_stage, next_rd_stage, rd_out, next_rd_out;
      logic mem_we;

      always_comb begin
        next_ack = link.bist_req; // [R10]
        // Operations before the acknowledge are ignored.
        mem_we = ack && link.bist_wren; // [R10]
        next_raddr = (ack && link.bist_rden) ? link.bist_addr : raddr;
        // Address, array and output stages give data in the third cycle.
        next_rd_stage = mem[raddr]; // [R12]
        next_rd_out = rd_stage; // [R12]
      end

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          ack <= 1'b0;
          raddr <= '0;
          rd_stage <= '0;
          rd_out <= '0;
        end else begin
          ack <= next_ack;
          raddr <= next_raddr;
          rd_stage <= next_rd_stage;
          rd_out <= next_rd_out;
        end
      end

      // Storage is left out of reset on purpose; only written rows are meaningful.
      always_ff @(posedge i_clock) begin
        if (mem_we) begin
          mem[link.bist_addr] <= link.bist_wdata;
        end
      end

      assign link.bist_ack = ack;
      assign link.bist_rdata = rd_out;
    end else begin : g_no_bist
      assign link.bist_ack = 1'b0; // [R09]
      assign link.bist_rdata = '0;
    end
  endgenerate
endmodule

`default_nettype wire

// ---- tumsb_host.sv ----
// Far end: issues sideband transactions, drives self-test and tie-offs, counts events.
// Assumes software uses a plain strobe port; read data appear one cycle after i_rd.
`timescale 1ns/1ns
`default_nettype none

module tumsb_host
  import tumsb_pkg::*;
#(
  parameter int ROW_AW = ROW_AW_DEF,
  parameter bit CTTW_VALUE = 1'b1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Link
  tumsb_if.host_mp link,
  // Register port
  input wire logic [REG_AW-1:0] i_addr,
  input wire logic [REG_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [REG_DW-1:0] o_rdata
);
  function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [REG_AW-1:0] evt_off(input int i);
    evt_off = REG_EVT_BASE + REG_AW'(4 * i);
  endfunction

  // ****************************************
  // Controller state
  // ****************************************
  logic [2:0] ctrl, next_ctrl;
  logic arv, next_arv, awv, next_awv, ns, next_ns;
  logic [SID_W-1:0] sid, next_sid;
  logic [SSD_W-1:0] ssd, next_ssd;
  logic wren, next_wren;
  logic [BIST_RD_LAT:0] rpipe, next_rpipe;
  logic [ROW_AW-1:0] baddr, next_baddr;
  logic [BIST_DW-1:0] bwdata, next_bwdata, bcap, next_bcap;
  tumsb_bist_t st, next_st;
  logic [CNT_W-1:0] cnt [N_EVT];
  logic [CNT_W-1:0] next_cnt [N_EVT];
  logic [REG_DW-1:0] rdata, next_rdata;
  logic [N_EVT-1:0] ev;
  logic [7:0] ints;

  assign ev = {link.ev_rd_refill, link.ev_wr_refill, link.ev_rd_access,
    link.ev_wr_access, link.cycle_div_tick_event, link.ev_cycle};
  assign ints = {link.secure_merged_int, link.nonsecure_merged_int,
    link.nonsecure_context_fault_int, link.perf_int, link.nonsecure_global_fault_int,
    link.secure_global_fault_int, link.nonsecure_config_fault_int,
    link.secure_config_fault_int};

  always_comb begin
    next_ctrl = ctrl;
    next_arv = 1'b0;
    next_awv = 1'b0;
    next_ns = ns;
    next_sid = sid;
    next_ssd = ssd;
    next_wren = 1'b0;
    next_rpipe = {rpipe[BIST_RD_LAT-1:0], 1'b0};
    next_baddr = baddr;
    next_bwdata = bwdata;
    next_bcap = rpipe[BIST_RD_LAT] ? link.bist_rdata : bcap;
    next_st = st;
    next_rdata = '0;
    if (i_wr && hit(i_addr, REG_CTRL)) begin
      next_ctrl = i_wdata[2:0];
    end
    if (i_wr && hit(i_addr, REG_TXN)) begin
      // Attributes and valid change together, so they are qualified by the valid.
      next_arv = !i_wdata[TXN_WRITE_BIT]; // [R01]
      next_awv = i_wdata[TXN_WRITE_BIT]; // [R02]
      next_ns = i_wdata[TXN_NS_BIT];
      next_sid = i_wdata[TXN_SID_LSB +: SID_W]; // [R04]
      next_ssd = i_wdata[TXN_SSD_LSB +: SSD_W];
    end
    if (i_wr && hit(i_addr, REG_WLO)) begin
      next_bwdata[31:0] = i_wdata;
    end
    if (i_wr && hit(i_addr, REG_WHI)) begin
      next_bwdata[BIST_DW-1:32] = i_wdata[BIST_DW-33:0];
    end
    // Operations are dropped unless the device has acknowledged.
    if (i_wr && hit(i_addr, REG_BOP) && st == BIST_READY) begin // [R10]
      next_rpipe[0] = i_wdata[BOP_RD_BIT];
      next_wren = i_wdata[BOP_WR_BIT];
      next_baddr = i_wdata[BOP_ADDR_LSB +: ROW_AW]; // [R11]
    end
    case (st)
      BIST_IDLE: begin
        if (ctrl[CTRL_BIST_REQ_BIT]) begin
          next_st = BIST_WAIT;
        end
      end
      BIST_WAIT: begin
        if (!ctrl[CTRL_BIST_REQ_BIT]) begin
          next_st = BIST_IDLE;
        end else if (link.bist_ack) begin
          next_st = BIST_READY; // [R10]
        end
      end
      BIST_READY: begin
        if (!ctrl[CTRL_BIST_REQ_BIT] || !link.bist_ack) begin
          next_st = BIST_IDLE;
        end
      end
      default: begin
        next_st = BIST_IDLE;
      end
    endcase
    for (int i = 0; i < N_EVT; i++) begin
      next_cnt[i] = (i_wr && hit(i_addr, evt_off(i))) ? '0 : cnt[i];
      next_cnt[i] = next_cnt[i] + CNT_W'(ev[i]);
    end
    if (i_rd) begin
      case (i_addr)
        REG_CTRL: next_rdata = {29'h0, ctrl};
        REG_WLO: next_rdata = bwdata[31:0];
        REG_WHI: next_rdata = {12'h0, bwdata[BIST_DW-1:32]};
        REG_RLO: next_rdata = bcap[31:0];
        REG_RHI: next_rdata = {12'h0, bcap[BIST_DW-1:32]};
        REG_STAT: next_rdata = {15'h0, CTTW_VALUE, ints, 6'h0,
          st == BIST_READY, link.bist_ack};
        default: begin
          for (int i = 0; i < N_EVT; i++) begin
            if (hit(i_addr, evt_off(i))) begin
              next_rdata = cnt[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl <= CTRL_RESET;
      arv <= 1'b0;
      awv <= 1'b0;
      ns <= 1'b0;
      sid <= '0;
      ssd <= '0;
      wren <= 1'b0;
      rpipe <= '0;
      baddr <= '0;
      bwdata <= '0;
      bcap <= '0;
      st <= BIST_IDLE;
      rdata <= '0;
      for (int i = 0; i < N_EVT; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      ctrl <= next_ctrl;
      arv <= next_arv;
      awv <= next_awv;
      ns <= next_ns;
      sid <= next_sid;
      ssd <= next_ssd;
      wren <= next_wren;
      rpipe <= next_rpipe;
      baddr <= next_baddr;
      bwdata <= next_bwdata;
      bcap <= next_bcap;
      st <= next_st;
      rdata <= next_rdata;
      for (int i = 0; i < N_EVT; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // ****************************************
  // Link drive
  // ****************************************
  assign link.arvalid = arv;
  assign link.awvalid = awv;
  assign link.rd_nonsecure_side = ns;
  assign link.wr_nonsecure_side = ns;
  assign link.rd_ssd_index = ssd;
  assign link.wr_ssd_index = ssd;
  assign link.rd_source_identity = sid;
  assign link.wr_source_identity = sid;
  assign link.bist_req = ctrl[CTRL_BIST_REQ_BIT];
  assign link.bist_rden = rpipe[0];
  assign link.bist_wren = wren;
  assign link.bist_addr = baddr;
  assign link.bist_wdata = bwdata;
  assign link.sec_debug_en = ctrl[CTRL_SPNIDEN_BIT];
  // A parameter, so the walk tie-off cannot move after reset.
  assign link.coherent_walk = CTTW_VALUE; // [R14]
  assign link.scan_test = ctrl[CTRL_TEST_BIT];
  assign o_rdata = rdata;
endmodule

`default_nettype wire

// ---- tumsb_if.sv ----
// Link between the translation unit end and the master, self-test and counter end.
// Assumes both parties share i_clock; no clocking block, the testbench joins the ends.
`timescale 1ns/1ns
`default_nettype none

interface tumsb_if
  import tumsb_pkg::*;
#(
  parameter int ROW_AW = ROW_AW_DEF
);
  logic arvalid;
  logic awvalid;
  logic rd_nonsecure_side;
  logic wr_nonsecure_side;
  logic [SSD_W-1:0] rd_ssd_index;
  logic [SSD_W-1:0] wr_ssd_index;
  logic [SID_W-1:0] rd_source_identity;
  logic [SID_W-1:0] wr_source_identity;
  logic bist_req;
  logic bist_ack;
  logic bist_rden;
  logic bist_wren;
  logic [ROW_AW-1:0] bist_addr;
  logic [BIST_DW-1:0] bist_wdata;
  logic [BIST_DW-1:0] bist_rdata;
  logic secure_config_fault_int;
  logic nonsecure_config_fault_int;
  logic secure_global_fault_int;
  logic nonsecure_global_fault_int;
  logic perf_int;
  logic nonsecure_context_fault_int;
  logic nonsecure_merged_int;
  logic secure_merged_int;
  logic sec_debug_en;
  logic coherent_walk;
  logic scan_test;
  logic ev_cycle;
  logic cycle_div_tick_event;
  logic ev_wr_access;
  logic ev_rd_access;
  logic ev_wr_refill;
  logic ev_rd_refill;

  modport dev_mp (
    input arvalid, awvalid, rd_nonsecure_side, wr_nonsecure_side,
    input rd_ssd_index, wr_ssd_index, rd_source_identity, wr_source_identity,
    input bist_req, bist_rden, bist_wren, bist_addr, bist_wdata,
    input sec_debug_en, coherent_walk, scan_test,
    output bist_ack, bist_rdata,
    output secure_config_fault_int, nonsecure_config_fault_int,
    output secure_global_fault_int, nonsecure_global_fault_int,
    output perf_int, nonsecure_context_fault_int, nonsecure_merged_int, secure_merged_int,
    output ev_cycle, cycle_div_tick_event, ev_wr_access, ev_rd_access,
    output ev_wr_refill, ev_rd_refill
  );

  modport host_mp (
    output arvalid, awvalid, rd_nonsecure_side, wr_nonsecure_side,
    output rd_ssd_index, wr_ssd_index, rd_source_identity, wr_source_identity,
    output bist_req, bist_rden, bist_wren, bist_addr, bist_wdata,
    output sec_debug_en, coherent_walk, scan_test,
    input bist_ack, bist_rdata,
    input secure_config_fault_int, nonsecure_config_fault_int,
    input secure_global_fault_int, nonsecure_global_fault_int,
    input perf_int, nonsecure_context_fault_int, nonsecure_merged_int, secure_merged_int,
    input ev_cycle, cycle_div_tick_event, ev_wr_access, ev_rd_access,
    input ev_wr_refill, ev_rd_refill
  );
endinterface

`default_nettype wire

// ---- tumsb_pkg.sv ----
// Shared constants for the translation unit sideband, interrupt, self-test and event link.
// Assumes both ends run on one clock and one synchronous reset.
`default_nettype none

package tumsb_pkg;
  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int SID_W = 8;
  localparam int SSD_W = 8;
  localparam int BIST_DW = 52;
  localparam int ROW_AW_DEF = 6;
  localparam int BIST_RD_LAT = 3;
  localparam int DIV_TICK = 64;
  localparam int DIV_W = $clog2(DIV_TICK);
  localparam int CNT_W = 32;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  // ****************************************
  // Fault and event indices
  // ****************************************
  localparam int N_INT = 6;
  localparam int INT_CFG_S = 0;
  localparam int INT_CFG_NS = 1;
  localparam int INT_GLB_S = 2;
  localparam int INT_GLB_NS = 3;
  localparam int INT_PERF = 4;
  localparam int INT_CXT_NS = 5;
  localparam int N_EVT = 6;
  localparam int EV_CLK = 0;
  localparam int EV_DIV = 1;
  localparam int EV_WR_ACC = 2;
  localparam int EV_RD_ACC = 3;
  localparam int EV_WR_REF = 4;
  localparam int EV_RD_REF = 5;

  // ****************************************
  // Controller register map
  // ****************************************
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_TXN = 8'h04;
  localparam logic [REG_AW-1:0] REG_BOP = 8'h08;
  localparam logic [REG_AW-1:0] REG_WLO = 8'h0C;
  localparam logic [REG_AW-1:0] REG_WHI = 8'h10;
  localparam logic [REG_AW-1:0] REG_RLO = 8'h14;
  localparam logic [REG_AW-1:0] REG_RHI = 8'h18;
  localparam logic [REG_AW-1:0] REG_STAT = 8'h1C;
  localparam logic [REG_AW-1:0] REG_EVT_BASE = 8'h20;
  localparam int CTRL_BIST_REQ_BIT = 0;
  localparam int CTRL_SPNIDEN_BIT = 1;
  localparam int CTRL_TEST_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int TXN_WRITE_BIT = 0;
  localparam int TXN_NS_BIT = 1;
  localparam int TXN_SID_LSB = 8;
  localparam int TXN_SSD_LSB = 16;
  localparam int BOP_RD_BIT = 0;
  localparam int BOP_WR_BIT = 1;
  localparam int BOP_ADDR_LSB = 8;
  localparam int STAT_ACK_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_INT_LSB = 8;
  localparam int STAT_CTTW_BIT = 16;

  typedef enum logic [1:0] {
    BIST_IDLE = 2'b00,
    BIST_WAIT = 2'b01,
    BIST_READY = 2'b10
  } tumsb_bist_t;
endpackage

`default_nettype wire

// ---- tumsb_tb_top.sv ----
// Bench joining both ends of the link; software reaches the far end's registers.
// Assumes the register map and latencies of the shared package.
`timescale 1ns/1ns
`default_nettype none

module tumsb_tb_top
  import tumsb_pkg::*;
;
  logic i_clock, i_rst, i_wr, i_rd, i_rd_refill, i_wr_refill;
  logic o_rd_ns, o_wr_ns, o_coherent_walk, o_test_mode;
  logic [N_INT-1:0] i_fault_set, i_fault_clr;
  logic [REG_AW-1:0] i_addr;
  logic [REG_DW-1:0] i_wdata, o_rdata;
  logic [SID_W-1:0] o_rd_sid, o_wr_sid;
  logic [7:0] e;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  tumsb_if link_if ();
  tumsb_dev tumsb_dev_i (.i_clock(i_clock), .i_rst(i_rst), .link(link_if),
    .i_fault_set(i_fault_set), .i_fault_clr(i_fault_clr), .i_rd_refill(i_rd_refill),
    .i_wr_refill(i_wr_refill), .o_rd_valid(), .o_rd_ns(o_rd_ns), .o_rd_sid(o_rd_sid),
    .o_wr_valid(), .o_wr_ns(o_wr_ns), .o_wr_sid(o_wr_sid),
    .o_coherent_walk(o_coherent_walk), .o_test_mode(o_test_mode));
  tumsb_host tumsb_host_i (.i_clock(i_clock), .i_rst(i_rst), .link(link_if),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  tumsb_checker tumsb_checker_i (.i_clock(i_clock), .i_rst(i_rst),
    .arvalid(link_if.arvalid), .rd_nonsecure_side(link_if.rd_nonsecure_side),
    .sec_debug_en(link_if.sec_debug_en), .scan_test(link_if.scan_test),
    .bist_req(link_if.bist_req), .bist_ack(link_if.bist_ack),
    .bist_rden(link_if.bist_rden), .bist_wren(link_if.bist_wren),
    .bist_addr(link_if.bist_addr), .bist_wdata(link_if.bist_wdata),
    .bist_rdata(link_if.bist_rdata), .ev_cycle(link_if.ev_cycle),
    .cycle_div_tick_event(link_if.cycle_div_tick_event), .ev_rd_access(link_if.ev_rd_access),
    .secure_config_fault_int(link_if.secure_config_fault_int),
    .secure_global_fault_int(link_if.secure_global_fault_int),
    .secure_merged_int(link_if.secure_merged_int));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    samples_checked++;
    if (s !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
      input string n);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(n, x, o_rdata & m);
  endtask

  function automatic logic [7:0] ea(input int k);
    return REG_EVT_BASE + 8'(4 * k);
  endfunction

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {i_rst, i_wr, i_rd, i_rd_refill, i_wr_refill} = 5'h10;
    {i_fault_set, i_fault_clr, i_addr, i_wdata} = '0;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    rc(REG_STAT, 32'h0001FFFF, 32'h00010000, "stat");
    chk("walk", 32'h1, {31'h0, o_coherent_walk});
    wr(ea(EV_WR_ACC), 32'h0);
    wr(ea(EV_RD_ACC), 32'h0);
    wr(REG_TXN, 32'h003CA502);
    wr(REG_TXN, 32'h00115A01);
    repeat (3) @(posedge i_clock);
    #1;
    chk("rd_ns", 32'h1, {31'h0, o_rd_ns});
    chk("rd_sid", 32'hA5, {24'h0, o_rd_sid});
    chk("wr_ns", 32'h0, {31'h0, o_wr_ns});
    chk("wr_sid", 32'h5A, {24'h0, o_wr_sid});
    rc(ea(EV_WR_ACC), '1, 32'h0, "wr_acc_sec");
    wr(REG_CTRL, 32'h2);
    wr(REG_TXN, 32'h00115A01);
    repeat (3) @(posedge i_clock);
    rc(ea(EV_WR_ACC), '1, 32'h1, "wr_acc");
    rc(ea(EV_RD_ACC), '1, 32'h1, "rd_acc");
    for (int k = 0; k < N_INT; k++) begin
      e = (8'h01 << k) | ((k == INT_CFG_S || k == INT_GLB_S) ? 8'h80 : 8'h40);
      @(posedge i_clock);
      i_fault_set <= 6'(1 << k);
      i_fault_clr <= 6'(1 << k);
      @(posedge i_clock);
      {i_fault_set, i_fault_clr} <= '0;
      rc(REG_STAT, 32'hFF00, {16'h0, e, 8'h0}, "int_set");
      @(posedge i_clock) i_fault_clr <= 6'(1 << k);
      rc(REG_STAT, 32'hFF00, 32'h0, "int_clr");
    end
    wr(ea(EV_CLK), 32'h0);
    wr(ea(EV_DIV), 32'h0);
    repeat (190) @(posedge i_clock);
    rc(ea(EV_DIV), '1, 32'd3, "div");
    rc(ea(EV_CLK), '1, 32'd196, "clk");
    wr(REG_CTRL, 32'h6);
    repeat (3) @(posedge i_clock);
    wr(ea(EV_CLK), 32'h0);
    wr(REG_TXN, 32'h0000A502);
    repeat (20) @(posedge i_clock);
    #1;
    chk("test_mode", 32'h1, {31'h0, o_test_mode});
    rc(ea(EV_CLK), '1, 32'h0, "clk_frozen");
    rc(ea(EV_RD_ACC), '1, 32'h1, "rd_acc_test");
    wr(REG_CTRL, 32'h3);
    repeat (4) @(posedge i_clock);
    rc(REG_STAT, 32'h3, 32'h3, "ack");
    wr(REG_WHI, 32'h00012345);
    wr(REG_WLO, 32'h89ABCDEF);
    wr(REG_BOP, 32'h00000502);
    wr(REG_WLO, 32'h01234567);
    wr(REG_BOP, 32'h00000602);
    for (int r = 5; r < 7; r++) begin
      wr(REG_BOP, {16'h0, 8'(r), 8'h01});
      repeat (6) @(posedge i_clock);
      rc(REG_RLO, '1, (r == 5) ? 32'h89ABCDEF : 32'h01234567, "bist_lo");
      rc(REG_RHI, 32'hFFFFF, 32'h00012345, "bist_hi");
    end
    wr(ea(EV_RD_REF), 32'h0);
    wr(ea(EV_WR_REF), 32'h0);
    @(posedge i_clock);
    {i_rd_refill, i_wr_refill} <= 2'h3;
    @(posedge i_clock);
    {i_rd_refill, i_wr_refill} <= 2'h0;
    rc(ea(EV_RD_REF), '1, 32'h1, "rd_ref");
    rc(ea(EV_WR_REF), '1, 32'h1, "wr_ref");
    tally_and_finish();
  end
endmodule

`default_nettype wire
